// ### hdl/irq_flags_pkg.sv
/*
 Constants for the peripheral request flag register block.
 Assumes a 32-bit APB slave at 100 MHz pclk.
*/
package irq_flags_pkg;
  localparam logic [11:0] flags0_offset = 12'h000;
  localparam logic [11:0] pin_ctrl_offset = 12'h004;
  localparam logic [11:0] pin_flags_offset = 12'h008;
  localparam logic [11:0] pin_state_offset = 12'h00c;
  localparam int pin_count = 8;
  localparam int timer_flag_bit = 5;
  localparam int summary_flag_bit = 4;
  localparam int ext_flag_bit = 0;
  localparam int rise_en_lsb = 0;
  localparam int fall_en_lsb = 8;
  localparam logic [7:0] flags0_reset = 8'h00;
  localparam logic [15:0] pin_ctrl_reset = 16'h0000;
  localparam logic [7:0] pin_flags_reset = 8'h00;
endpackage : irq_flags_pkg

// ### hdl/pin_change_detect.sv
/*
 Per-pin change flags with rising and falling edge enables.
 Assumes pins are already synchronised to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_change_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] pin_sync,
  input wire logic [7:0] rising_edge_enable,
  input wire logic [7:0] falling_edge_enable,
  input wire logic [7:0] clear_mask,
  output logic [7:0] per_pin_change_flags
);
  logic [7:0] pin_prev;
  logic [7:0] edge_hit;

  // Previous pin level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 8'h00;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  assign edge_hit = (pin_sync & ~pin_prev & rising_edge_enable) | (~pin_sync & pin_prev & falling_edge_enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_pin_change_flags <= irq_flags_pkg::pin_flags_reset;
    end else begin
      per_pin_change_flags <= (per_pin_change_flags & ~clear_mask) | edge_hit;
    end
  end

  a_masked_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (per_pin_change_flags & ~$past(per_pin_change_flags)
     & ~($past(rising_edge_enable) | $past(falling_edge_enable))) == 8'h00)
    else $error("masked pin set its flag");
endmodule : pin_change_detect
`default_nettype wire

// ### hdl/irq_flags.sv
/*
 Peripheral request flag register 0 with an APB slave.
 Assumes timer_overflow is a one-cycle pulse on pclk; ext_pin and
 change_pins are asynchronous pins and are synchronised here.
*/
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - Timer overflow sets bit 5, software clears
// - Summary bit 4 ignores software writes
// - Summary reads one when change flag set
// - Summary is OR of all change flags
// - Bits 3 to 1 read zero
// - External pin event sets bit 0
// - Pins masked by rising/falling enables
// - Timer and external flags set regardless of any enable
// - Bits 7 and 6 read zero
module irq_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_overflow,
  input wire logic ext_pin,
  input wire logic [7:0] change_pins,
  output logic pin_change_summary_flag
);
  logic timer0_overflow_flag;
  logic external_pin_event_flag;
  logic [15:0] pin_ctrl;
  logic [7:0] per_pin_change_flags;
  logic [1:0] ext_sync;
  logic ext_prev;
  logic [7:0] pins_meta;
  logic [7:0] pins_sync;
  logic wr_access;
  logic rd_access;
  logic wr_flags0;
  logic [7:0] pin_clear;
  logic ext_event;
  logic [7:0] peripheral_request_flags_0;
  logic mapped;
  logic [31:0] next_prdata;

  // Setup phase of a transfer; the answer is launched from it
  function automatic logic setup_phase(input logic sel, input logic en);
    return sel & ~en;
  endfunction : setup_phase

  // Two-stage synchronisers for the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync <= 2'b00;
      ext_prev <= 1'b0;
      pins_meta <= 8'h00;
      pins_sync <= 8'h00;
    end else begin
      ext_sync <= {ext_sync[0], ext_pin};
      ext_prev <= ext_sync[1];
      pins_meta <= change_pins;
      pins_sync <= pins_meta;
    end
  end

  // Rising edge of the external pin is the event
  assign ext_event = ext_sync[1] & ~ext_prev;

  // Zero-wait APB: access phase completes at once
  assign wr_access = psel & penable & pwrite;
  assign rd_access = psel & penable & ~pwrite;
  assign wr_flags0 = wr_access & pstrb[0] & (paddr == irq_flags_pkg::flags0_offset);
  // Write-one-to-clear on the per-pin flags register
  assign pin_clear = (wr_access && pstrb[0] && paddr == irq_flags_pkg::pin_flags_offset) ? pwdata[7:0] : 8'h00;

  // timer flag; set wins; no enable gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_overflow_flag <= irq_flags_pkg::flags0_reset[irq_flags_pkg::timer_flag_bit];
    end else if (timer_overflow) begin
      timer0_overflow_flag <= 1'b1;
    end else if (wr_flags0) begin
      timer0_overflow_flag <= pwdata[irq_flags_pkg::timer_flag_bit];
    end
  end

  // external flag; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_pin_event_flag <= irq_flags_pkg::flags0_reset[irq_flags_pkg::ext_flag_bit];
    end else if (ext_event) begin
      external_pin_event_flag <= 1'b1;
    end else if (wr_flags0) begin
      external_pin_event_flag <= pwdata[irq_flags_pkg::ext_flag_bit];
    end
  end

  // Edge enables, software control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ctrl <= irq_flags_pkg::pin_ctrl_reset;
    end else if (wr_access && paddr == irq_flags_pkg::pin_ctrl_offset) begin
      if (pstrb[0]) begin
        pin_ctrl[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        pin_ctrl[15:8] <= pwdata[15:8];
      end
    end
  end

  pin_change_detect u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .pin_sync(pins_sync),
    .rising_edge_enable(pin_ctrl[irq_flags_pkg::rise_en_lsb +: 8]),
    .falling_edge_enable(pin_ctrl[irq_flags_pkg::fall_en_lsb +: 8]),
    .clear_mask(pin_clear),
    .per_pin_change_flags(per_pin_change_flags)
  );

  // summary is read-only OR, unused bits zero
  assign peripheral_request_flags_0 = {2'b00, timer0_overflow_flag, |per_pin_change_flags,
                                       3'b000, external_pin_event_flag};

  // Read mux; unmapped address reads zero with error
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      irq_flags_pkg::flags0_offset: next_prdata = {24'h00_0000, peripheral_request_flags_0};
      irq_flags_pkg::pin_ctrl_offset: next_prdata = {16'h0000, pin_ctrl};
      irq_flags_pkg::pin_flags_offset: next_prdata = {24'h00_0000, per_pin_change_flags};
      irq_flags_pkg::pin_state_offset: next_prdata = {24'h00_0000, pins_sync};
      default: mapped = 1'b0;
    endcase
  end

  // Registered answer: pready high in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase(psel, penable);
      pslverr <= setup_phase(psel, penable) & ~mapped;
      prdata <= (setup_phase(psel, penable) & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_summary_flag <= 1'b0;
    end else begin
      pin_change_summary_flag <= |per_pin_change_flags;
    end
  end

  a_timer_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    timer_overflow |=> timer0_overflow_flag)
    else $error("timer flag not set after overflow");
  a_timer_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (timer0_overflow_flag && !wr_flags0) |=> timer0_overflow_flag)
    else $error("timer flag dropped without clear");
  a_ext_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ext_event |=> external_pin_event_flag)
    else $error("external flag not set");
  a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_flags0 |=> (timer0_overflow_flag || !$past(timer_overflow)) && (external_pin_event_flag || !$past(ext_event)))
    else $error("clear won over set");
  a_summary_or: assert property (@(posedge pclk) disable iff (!presetn)
    pin_change_summary_flag == |$past(per_pin_change_flags))
    else $error("summary is not OR of change flags");
  a_summary_readonly: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flags0 && pwdata[irq_flags_pkg::summary_flag_bit] && per_pin_change_flags == 8'h00)
    |=> pin_change_summary_flag == 1'b0)
    else $error("write changed summary flag");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && rd_access && $past(paddr) == irq_flags_pkg::flags0_offset) |-> prdata[3:1] == 3'b000)
    else $error("bits 3 to 1 not zero");
  a_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[7:6] == 2'b00 || $past(paddr) != irq_flags_pkg::flags0_offset)
    else $error("bits 7 and 6 not zero");
  a_summary_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == irq_flags_pkg::flags0_offset)
    |=> prdata[4] == |$past(per_pin_change_flags))
    else $error("summary read mismatch");

  // only an overflow or a write sets it
  a_timer_no_stray: assert property (@(posedge pclk) disable iff (!presetn)
    (!timer0_overflow_flag && !timer_overflow && !(wr_flags0 && pwdata[irq_flags_pkg::timer_flag_bit]))
    |=> !timer0_overflow_flag)
    else $error("timer flag set with no cause");

  a_timer_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flags0 && !pwdata[irq_flags_pkg::timer_flag_bit] && !timer_overflow) |=> !timer0_overflow_flag)
    else $error("timer flag not cleared by write");

  a_ext_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (external_pin_event_flag && !wr_flags0) |=> external_pin_event_flag)
    else $error("external flag dropped without clear");

  // only a pin event or a write sets it
  a_ext_no_stray: assert property (@(posedge pclk) disable iff (!presetn)
    (!external_pin_event_flag && !ext_event && !(wr_flags0 && pwdata[irq_flags_pkg::ext_flag_bit]))
    |=> !external_pin_event_flag)
    else $error("external flag set with no cause");

  a_ext_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flags0 && !pwdata[irq_flags_pkg::ext_flag_bit] && !ext_event) |=> !external_pin_event_flag)
    else $error("external flag not cleared by write");
endmodule : irq_flags
`default_nettype wire

// ### bench/event_source_model.sv
/*
 Event source model: timer overflow pulse, external pin, change pins.
 Assumes the bench calls its tasks from a pclk-synchronous process.
*/
`timescale 1ns/100ps
`default_nettype none
module event_source_model (
  input wire logic pclk,
  output logic timer_overflow,
  output logic ext_pin,
  output logic [7:0] change_pins
);
  // Quiet sources until the bench asks
  initial begin
    timer_overflow = 1'h0;
    ext_pin = 1'h0;
    change_pins = 8'h00;
  end
  // One-cycle pulse after a lead of some edges
  task automatic pulse_timer(input int lead);
    repeat (lead) @(posedge pclk);
    timer_overflow <= 1'h1;
    @(posedge pclk);
    timer_overflow <= 1'h0;
  endtask : pulse_timer
  // Pads move just after an edge, never on it
  task automatic set_pins(input logic ext, input logic [7:0] pins);
    @(posedge pclk);
    ext_pin <= ext;
    change_pins <= pins;
  endtask : set_pins
endmodule : event_source_model
`default_nettype wire

// ### bench/irq_flags_tb_top.sv
/*
 Self-checking bench for the request flag register block.
 Assumes an APB slave answering in its own time and the event model.
*/
`timescale 1ns/100ps
`default_nettype none
module irq_flags_tb_top;
  localparam logic [11:0] fa = irq_flags_pkg::flags0_offset;
  localparam logic [11:0] ca = irq_flags_pkg::pin_ctrl_offset;
  localparam logic [11:0] pa = irq_flags_pkg::pin_flags_offset;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic timer_overflow, ext_pin, summary;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] change_pins;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  irq_flags irq_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_overflow(timer_overflow), .ext_pin(ext_pin),
    .change_pins(change_pins), .pin_change_summary_flag(summary));
  event_source_model event_source_model_i (.pclk(pclk), .timer_overflow(timer_overflow),
    .ext_pin(ext_pin), .change_pins(change_pins));
  // 100 MHz clock
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard, far above the hundred or so cycles used
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Setup, then access held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(fa, 32'h0);
    rdchk(ca, 32'h0);
    // Overflow sets bit 5 with every enable off; writing zero clears
    event_source_model_i.pulse_timer(1);
    rdchk(fa, 32'h20);
    apb(1'h1, fa, 32'h0);
    rdchk(fa, 32'h0);
    // Read-only and unimplemented bits ignore writes
    apb(1'h1, fa, 32'hff);
    rdchk(fa, 32'h21);
    apb(1'h1, fa, 32'h0);
    // External pin edge, through the synchroniser
    event_source_model_i.set_pins(1'h1, 8'h00);
    repeat (4) @(posedge pclk);
    rdchk(fa, 32'h01);
    apb(1'h1, fa, 32'h0);
    rdchk(fa, 32'h0);
    // Both edge enables off: pin 3 is masked
    event_source_model_i.set_pins(1'h0, 8'h08);
    repeat (4) @(posedge pclk);
    rdchk(pa, 32'h0);
    // Rising enable on pin 3 only; fall first, then rise
    apb(1'h1, ca, 32'h0008);
    event_source_model_i.set_pins(1'h0, 8'h00);
    event_source_model_i.set_pins(1'h0, 8'h08);
    repeat (4) @(posedge pclk);
    rdchk(pa, 32'h08);
    rdchk(fa, 32'h10);
    chk({31'h0, summary}, 32'h1);
    apb(1'h1, fa, 32'h0);
    rdchk(fa, 32'h10);
    apb(1'h1, pa, 32'h08);
    rdchk(fa, 32'h0);
    // Falling enable catches the drop
    apb(1'h1, ca, 32'h0800);
    event_source_model_i.set_pins(1'h0, 8'h00);
    repeat (4) @(posedge pclk);
    rdchk(pa, 32'h08);
    // Unmapped place answers zero with an error
    apb(1'h0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Overflow lands on the same edge as a clearing write
    fork
      event_source_model_i.pulse_timer(2);
      apb(1'h1, fa, 32'h0);
    join
    rdchk(fa, 32'h30);
    print_verdict();
  end
endmodule : irq_flags_tb_top
`default_nettype wire
